// *** rtl/dcpim_mapper.sv ***
`timescale 1ns/10ps
`include "dcpim_defines.svh"
// Summary of operation
// - the image_size_select_bit picks the layout, one for compact and zero for complete.
// - after reset the bit is set, so the compact layout is active on a compact-mapping coupler.
// - compact layout exchanges eight input and eight output bytes and needs a compact-mapping coupler.
// - compact output is control one, reserved, control two, reserved, shared preset; input is word one, word two.
// - in compact layout the shared preset word feeds both counters.
// - compact layout offers no register communication.
// - bit 1 of each channel's control byte picks live counter or latched value for its input word.
// - complete layout exchanges ten bytes each way with a complete-mapping coupler and the bit cleared.
// - complete layout is status, word, status, word in and control, preset, control, preset out.
// - in complete layout each control/status pair serves register or process operation, one at a time.
// - with the bit set on a complete coupler, the mixed layout with separate register bytes applies.
// - in mixed layout only bit 7 of the register control byte enables register communication.
// - in mixed layout register bytes and process bytes never swap meaning.
// - register control byte is enable bit 7, write bit 6, register number bits 5 to 0.
// - counter data is not valid while register communication is active.
module dcpim_mapper #(
  parameter int IMG_BYTES = `DCPIM_IMG_BYTES
) (
  input wire logic core_clk, // 125 MHz clock
  input wire logic reset_n, // sync reset, active low
  input wire logic size_sel_wr, // write strobe for image_size_select_bit
  input wire logic size_sel_wdata, // value written
  input wire logic coupler_complete, // coupler set to complete mapping
  input wire logic [IMG_BYTES*8-1:0] out_image, // bytes from coupler, byte 0 low
  input wire logic [31:0] ch1_counter_word, // live counter 1
  input wire logic [31:0] ch2_counter_word, // live counter 2
  input wire logic [31:0] ch1_latch_word, // latched value 1
  input wire logic [31:0] ch2_latch_word, // latched value 2
  input wire logic [7:0] ch1_status_byte, // process status 1
  input wire logic [7:0] ch2_status_byte, // process status 2
  input wire logic [7:0] ch1_regcomm_status_byte, // register status 1
  input wire logic [7:0] ch2_regcomm_status_byte, // register status 2
  output logic [IMG_BYTES*8-1:0] in_image, // bytes to coupler
  output logic [3:0] image_bytes, // active image length
  output logic image_size_select_bit, // current feature bit
  output logic [7:0] ch1_process_control_byte, // process control 1
  output logic [7:0] ch2_process_control_byte, // process control 2
  output logic [31:0] ch1_preset_word, // preset for counter 1
  output logic [31:0] ch2_preset_word, // preset for counter 2
  output logic ch1_register_comm_enable, // register access on ch1
  output logic ch2_register_comm_enable, // register access on ch2
  output dcpim_pkg::dcpim_rc_t ch1_regcomm_req, // register request ch1
  output dcpim_pkg::dcpim_rc_t ch2_regcomm_req // register request ch2
);
  typedef struct packed {
    logic size_sel;
    dcpim_pkg::dcpim_layout_t layout;
    logic [IMG_BYTES*8-1:0] in_image;
    logic [7:0] pd1;
    logic [7:0] pd2;
    logic [7:0] rc1;
    logic [7:0] rc2;
    logic [31:0] pre1;
    logic [31:0] pre2;
  } dcpim_st_t;

  dcpim_st_t st_r;
  dcpim_st_t st_nxt;
  dcpim_chan_if c1 ();
  dcpim_chan_if c2 ();

  function automatic logic [7:0] get_byte(input logic [IMG_BYTES*8-1:0] img, input int idx);
    get_byte = img[idx*8 +: 8];
  endfunction : get_byte

  function automatic logic [31:0] get_word(input logic [IMG_BYTES*8-1:0] img, input int idx);
    get_word = img[idx*8 +: 32];
  endfunction : get_word

  function automatic dcpim_pkg::dcpim_layout_t pick_layout(input logic sel, input logic full);
    if (!sel) begin
      pick_layout = dcpim_pkg::DCPIM_LAY_COMPLETE;
    end else if (full) begin
      pick_layout = dcpim_pkg::DCPIM_LAY_MIXED;
    end else begin
      pick_layout = dcpim_pkg::DCPIM_LAY_COMPACT;
    end
  endfunction : pick_layout

  always_comb begin
    st_nxt = st_r;
    if (size_sel_wr) begin
      st_nxt.size_sel = size_sel_wdata;
    end
    st_nxt.layout = pick_layout(st_r.size_sel, coupler_complete);
    st_nxt.in_image = '0;
    // reserved output bytes are never sampled
    unique case (st_r.layout)
      dcpim_pkg::DCPIM_LAY_COMPACT: begin
        st_nxt.pd1 = get_byte(out_image, `DCPIM_CP_OUT_CB1);
        st_nxt.pd2 = get_byte(out_image, `DCPIM_CP_OUT_CB2);
        st_nxt.rc1 = '0;
        st_nxt.rc2 = '0;
        st_nxt.pre1 = get_word(out_image, `DCPIM_CP_OUT_PRE);
        st_nxt.pre2 = get_word(out_image, `DCPIM_CP_OUT_PRE);
        st_nxt.in_image[`DCPIM_CP_IN_W1*8 +: 32] = c1.in_word;
        st_nxt.in_image[`DCPIM_CP_IN_W2*8 +: 32] = c2.in_word;
      end
      dcpim_pkg::DCPIM_LAY_COMPLETE: begin
        // one control byte per channel, its meaning follows its bit 7
        st_nxt.pd1 = get_byte(out_image, `DCPIM_FL_OUT_CB1);
        st_nxt.pd2 = get_byte(out_image, `DCPIM_FL_OUT_CB2);
        st_nxt.rc1 = get_byte(out_image, `DCPIM_FL_OUT_CB1);
        st_nxt.rc2 = get_byte(out_image, `DCPIM_FL_OUT_CB2);
        st_nxt.pre1 = get_word(out_image, `DCPIM_FL_OUT_PRE1);
        st_nxt.pre2 = get_word(out_image, `DCPIM_FL_OUT_PRE2);
        st_nxt.in_image[`DCPIM_FL_IN_SB1*8 +: 8] = c1.in_status;
        st_nxt.in_image[`DCPIM_FL_IN_W1*8 +: 32] = c1.in_word;
        st_nxt.in_image[`DCPIM_FL_IN_SB2*8 +: 8] = c2.in_status;
        st_nxt.in_image[`DCPIM_FL_IN_W2*8 +: 32] = c2.in_word;
      end
      dcpim_pkg::DCPIM_LAY_MIXED: begin
        st_nxt.rc1 = get_byte(out_image, `DCPIM_MX_OUT_RC1);
        st_nxt.pd1 = get_byte(out_image, `DCPIM_MX_OUT_PD1);
        st_nxt.pd2 = get_byte(out_image, `DCPIM_MX_OUT_PD2);
        st_nxt.rc2 = get_byte(out_image, `DCPIM_MX_OUT_RC2);
        st_nxt.pre1 = get_word(out_image, `DCPIM_MX_OUT_PRE);
        st_nxt.pre2 = get_word(out_image, `DCPIM_MX_OUT_PRE);
        st_nxt.in_image[`DCPIM_MX_IN_SB1*8 +: 8] = c1.in_status;
        st_nxt.in_image[`DCPIM_MX_IN_W1*8 +: 32] = c1.in_word;
        st_nxt.in_image[`DCPIM_MX_IN_SB2*8 +: 8] = c2.in_status;
        st_nxt.in_image[`DCPIM_MX_IN_W2*8 +: 32] = c2.in_word;
      end
      default: st_nxt.layout = dcpim_pkg::DCPIM_LAY_COMPACT;
    endcase
    if (!reset_n) begin
      st_nxt = '0;
      st_nxt.size_sel = `DCPIM_SIZE_SEL_RST;
      st_nxt.layout = dcpim_pkg::DCPIM_LAY_COMPACT;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  assign c1.pd_ctrl = st_r.pd1;
  assign c1.rc_ctrl = st_r.rc1;
  assign c1.counter = ch1_counter_word;
  assign c1.latched = ch1_latch_word;
  // in register mode the status slot carries the register acknowledge
  assign c1.status = (st_r.layout == dcpim_pkg::DCPIM_LAY_MIXED || c1.regcomm_en) ?
                     ch1_regcomm_status_byte : ch1_status_byte;
  assign c1.preset = st_r.pre1;
  assign c2.pd_ctrl = st_r.pd2;
  assign c2.rc_ctrl = st_r.rc2;
  assign c2.counter = ch2_counter_word;
  assign c2.latched = ch2_latch_word;
  assign c2.status = (st_r.layout == dcpim_pkg::DCPIM_LAY_MIXED || c2.regcomm_en) ?
                     ch2_regcomm_status_byte : ch2_status_byte;
  assign c2.preset = st_r.pre2;

  dcpim_chan u_ch1 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .layout(st_r.layout),
    .ch(c1.chan)
  );
  dcpim_chan u_ch2 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .layout(st_r.layout),
    .ch(c2.chan)
  );

  // data words stay as captured but are not valid while register access runs
  assign in_image = st_r.in_image;
  assign image_bytes = (st_r.layout == dcpim_pkg::DCPIM_LAY_COMPACT) ?
                       4'(`DCPIM_COMPACT_BYTES) : 4'(`DCPIM_COMPLETE_BYTES);
  assign image_size_select_bit = st_r.size_sel;
  assign ch1_process_control_byte = st_r.pd1;
  assign ch2_process_control_byte = st_r.pd2;
  assign ch1_preset_word = st_r.pre1;
  assign ch2_preset_word = st_r.pre2;
  assign ch1_register_comm_enable = c1.regcomm_en;
  assign ch2_register_comm_enable = c2.regcomm_en;
  assign ch1_regcomm_req = c1.regcomm_en ? dcpim_pkg::dcpim_rc_t'(st_r.rc1) : '0;
  assign ch2_regcomm_req = c2.regcomm_en ? dcpim_pkg::dcpim_rc_t'(st_r.rc2) : '0;
endmodule : dcpim_mapper

// *** rtl/dcpim_defines.svh ***
`ifndef DCPIM_DEFINES_SVH
`define DCPIM_DEFINES_SVH
// image sizes in bytes
`define DCPIM_COMPACT_BYTES 8
`define DCPIM_COMPLETE_BYTES 10
`define DCPIM_IMG_BYTES 10
// feature bit reset value: compact image on delivery
`define DCPIM_SIZE_SEL_RST 1'b1
// control byte fields
`define DCPIM_CB_REGCOMM_BIT 7
`define DCPIM_CB_WRITE_BIT 6
`define DCPIM_CB_REGNO_MSB 5
`define DCPIM_CB_VALSEL_BIT 1
// byte positions, compact
`define DCPIM_CP_OUT_CB1 0
`define DCPIM_CP_OUT_CB2 2
`define DCPIM_CP_OUT_PRE 4
`define DCPIM_CP_IN_W1 0
`define DCPIM_CP_IN_W2 4
// byte positions, complete
`define DCPIM_FL_OUT_CB1 0
`define DCPIM_FL_OUT_PRE1 1
`define DCPIM_FL_OUT_CB2 5
`define DCPIM_FL_OUT_PRE2 6
`define DCPIM_FL_IN_SB1 0
`define DCPIM_FL_IN_W1 1
`define DCPIM_FL_IN_SB2 5
`define DCPIM_FL_IN_W2 6
// byte positions, mixed (compact on complete coupler)
`define DCPIM_MX_OUT_RC1 0
`define DCPIM_MX_OUT_PD1 1
`define DCPIM_MX_OUT_PD2 3
`define DCPIM_MX_OUT_RC2 5
`define DCPIM_MX_OUT_PRE 6
`define DCPIM_MX_IN_SB1 0
`define DCPIM_MX_IN_W1 1
`define DCPIM_MX_IN_SB2 5
`define DCPIM_MX_IN_W2 6
`endif

// *** rtl/dcpim_pkg.sv ***
package dcpim_pkg;
  typedef enum logic [2:0] {
    DCPIM_LAY_COMPACT = 3'b001,
    DCPIM_LAY_COMPLETE = 3'b010,
    DCPIM_LAY_MIXED = 3'b100
  } dcpim_layout_t;
  typedef struct packed {
    logic regcomm;
    logic write;
    logic [5:0] regno;
  } dcpim_rc_t;
endpackage : dcpim_pkg

// *** rtl/dcpim_chan_if.sv ***
`timescale 1ns/10ps
interface dcpim_chan_if;
  logic [7:0] pd_ctrl;
  logic [7:0] rc_ctrl;
  logic [7:0] status;
  logic [31:0] counter;
  logic [31:0] latched;
  logic [31:0] preset;
  logic regcomm_en;
  logic [31:0] in_word;
  logic [7:0] in_status;
  modport mapper (output pd_ctrl, rc_ctrl, status, counter, latched, preset, input regcomm_en, in_word, in_status);
  modport chan (input pd_ctrl, rc_ctrl, status, counter, latched, preset, output regcomm_en, in_word, in_status);
endinterface : dcpim_chan_if

// *** rtl/dcpim_chan.sv ***
`timescale 1ns/10ps
`include "dcpim_defines.svh"
module dcpim_chan (
  input wire logic core_clk, // clock
  input wire logic reset_n, // sync reset
  input wire dcpim_pkg::dcpim_layout_t layout, // active layout
  dcpim_chan_if.chan ch // channel bundle
);
  typedef struct packed {
    logic regcomm_en;
    logic [31:0] in_word;
    logic [7:0] in_status;
  } dcpim_chan_st_t;
  dcpim_chan_st_t st_r;
  dcpim_chan_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    unique case (layout)
      dcpim_pkg::DCPIM_LAY_COMPACT: st_nxt.regcomm_en = 1'b0;
      dcpim_pkg::DCPIM_LAY_COMPLETE: st_nxt.regcomm_en = ch.pd_ctrl[`DCPIM_CB_REGCOMM_BIT];
      dcpim_pkg::DCPIM_LAY_MIXED: st_nxt.regcomm_en = ch.rc_ctrl[`DCPIM_CB_REGCOMM_BIT];
      default: st_nxt.regcomm_en = 1'b0;
    endcase
    // value select only meaningful in process-data operation
    st_nxt.in_word = ch.pd_ctrl[`DCPIM_CB_VALSEL_BIT] ? ch.latched : ch.counter;
    st_nxt.in_status = ch.status;
    if (!reset_n) begin
      st_nxt = '0;
    end
  end
  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end
  assign ch.regcomm_en = st_r.regcomm_en;
  assign ch.in_word = st_r.in_word;
  assign ch.in_status = st_r.in_status;
endmodule : dcpim_chan

// *** tb/dcpim_coupler_model.sv ***
`timescale 1ns/10ps
module dcpim_coupler_model (
  input wire logic core_clk, // clock
  output logic [79:0] out_image, // bytes to device
  output logic coupler_complete // mapping mode
);
  initial begin
    out_image = 80'h0000_0000_0000_0000_0000;
    coupler_complete = 1'b0;
  end
  // the device samples every edge, so a mode change lands between edges
  task automatic set_mode(input logic full);
    @(posedge core_clk);
    #1 coupler_complete = full;
  endtask : set_mode
  task automatic send(input logic [79:0] img);
    @(posedge core_clk);
    #1 out_image = img;
  endtask : send
  function automatic logic [7:0] rc_byte(input logic en, input logic wr, input logic [5:0] no);
    return {en, wr, no};
  endfunction : rc_byte
endmodule : dcpim_coupler_model

// *** tb/dcpim_mapper_assertions.sv ***
`timescale 1ns/10ps
module dcpim_mapper_assertions #(
  parameter int IMG_BYTES = 10
) (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic size_sel_wr, // bit write
  input wire logic size_sel_wdata, // bit value
  input wire logic coupler_complete, // coupler mode
  input wire logic [IMG_BYTES*8-1:0] out_image, // coupler bytes
  input wire logic [3:0] image_bytes, // length
  input wire logic image_size_select_bit, // feature bit
  input wire logic [7:0] ch1_process_control_byte, // control 1
  input wire logic [31:0] ch1_preset_word, // preset 1
  input wire logic [31:0] ch2_preset_word, // preset 2
  input wire logic ch1_register_comm_enable, // access 1
  input wire logic ch2_register_comm_enable, // access 2
  input wire dcpim_pkg::dcpim_rc_t ch1_regcomm_req, // request 1
  input wire dcpim_pkg::dcpim_rc_t ch2_regcomm_req // request 2
);
  logic cmp;
  logic mix;
  assign cmp = image_size_select_bit && !coupler_complete;
  assign mix = image_size_select_bit && coupler_complete;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_bit_write: assert property (size_sel_wr |=> image_size_select_bit == $past(size_sel_wdata))
    else $error("bit write lost");
  a_reset_compact: assert property ($rose(reset_n) |-> image_size_select_bit && image_bytes == 4'h8)
    else $error("not compact after reset");
  a_compact_len: assert property (cmp [*3] |-> image_bytes == 4'h8)
    else $error("compact length");
  a_full_len: assert property ((!cmp) [*3] |-> image_bytes == 4'ha)
    else $error("complete length");
  a_shared_preset: assert property (cmp [*3] |=> ch1_preset_word == $past(out_image[63:32])
    && ch2_preset_word == ch1_preset_word) else $error("shared preset");
  a_compact_noreg: assert property (cmp [*4] |-> !ch1_register_comm_enable && !ch2_register_comm_enable)
    else $error("register access in compact");
  a_complete_map: assert property ((!image_size_select_bit) [*3] |=>
    ch2_preset_word == $past(out_image[79:48]) && ch1_process_control_byte == $past(out_image[7:0]))
    else $error("complete map");
  a_mixed_enable: assert property ((mix && $stable(out_image)) [*4] |->
    ch1_register_comm_enable == out_image[7]) else $error("mixed enable");
  a_mixed_request: assert property ((mix && $stable(out_image)) [*4] |->
    ch2_regcomm_req == (out_image[47] ? out_image[47:40] : 8'h00)) else $error("mixed request");
  cover property (cmp [*3]);
  cover property (mix && ch2_register_comm_enable);
  cover property (!image_size_select_bit && ch1_register_comm_enable);
endmodule : dcpim_mapper_assertions
bind dcpim_mapper dcpim_mapper_assertions #(.IMG_BYTES(IMG_BYTES)) i_dcpim_mapper_assertions (.core_clk, .reset_n,
  .size_sel_wr, .size_sel_wdata, .coupler_complete, .out_image, .image_bytes, .image_size_select_bit,
  .ch1_process_control_byte, .ch1_preset_word, .ch2_preset_word, .ch1_register_comm_enable,
  .ch2_register_comm_enable, .ch1_regcomm_req, .ch2_regcomm_req);

// *** tb/dcpim_mapper_test.sv ***
`timescale 1ns/10ps
module dcpim_mapper_test;
  logic core_clk, reset_n, size_sel_wr, size_sel_wdata, coupler_complete, image_size_select_bit;
  logic [31:0] ch1_counter_word, ch2_counter_word, ch1_latch_word, ch2_latch_word, ch1_preset_word, ch2_preset_word;
  logic [7:0] ch1_status_byte, ch2_status_byte, ch1_regcomm_status_byte, ch2_regcomm_status_byte;
  logic [7:0] ch1_process_control_byte, ch2_process_control_byte;
  logic [79:0] out_image, in_image;
  logic [3:0] image_bytes;
  logic ch1_register_comm_enable, ch2_register_comm_enable;
  dcpim_pkg::dcpim_rc_t ch1_regcomm_req, ch2_regcomm_req;
  int n_errors = 0;
  int checks_done = 0;
  dcpim_mapper i_dcpim_mapper (.core_clk, .reset_n, .size_sel_wr, .size_sel_wdata, .coupler_complete, .out_image,
    .ch1_counter_word, .ch2_counter_word, .ch1_latch_word, .ch2_latch_word, .ch1_status_byte, .ch2_status_byte,
    .ch1_regcomm_status_byte, .ch2_regcomm_status_byte, .in_image, .image_bytes, .image_size_select_bit,
    .ch1_process_control_byte, .ch2_process_control_byte, .ch1_preset_word, .ch2_preset_word,
    .ch1_register_comm_enable, .ch2_register_comm_enable, .ch1_regcomm_req, .ch2_regcomm_req);
  dcpim_coupler_model i_dcpim_coupler_model (.core_clk, .out_image, .coupler_complete);
  task automatic check_val(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic write_size(input logic v);
    @(posedge core_clk);
    #1 size_sel_wr = 1'b1;
    size_sel_wdata = v;
    @(posedge core_clk);
    #1 size_sel_wr = 1'b0;
  endtask : write_size
  // fresh values per test so a stale word cannot pass
  task automatic load(input logic [7:0] k);
    {ch1_counter_word, ch2_counter_word} = {k, 24'h10_0001, k, 24'h20_0002};
    {ch1_latch_word, ch2_latch_word} = {k, 24'h30_0003, k, 24'h40_0004};
    {ch1_status_byte, ch2_status_byte} = {k ^ 8'h10, k ^ 8'h20};
    {ch1_regcomm_status_byte, ch2_regcomm_status_byte} = {k ^ 8'h30, k ^ 8'h40};
  endtask : load
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (300) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    size_sel_wr = 1'b0;
    size_sel_wdata = 1'b0;
    load(8'h00);
    repeat (4) @(posedge core_clk);
    #1 reset_n = 1'b1;
    check_val({image_size_select_bit, image_bytes}, 5'h18);
    $display("reset test done");
    load(8'ha1);
    i_dcpim_coupler_model.send({16'hffff, 32'hdead_beef, 8'hff, 8'h02, 8'hff, 8'h80});
    settle();
    check_val(in_image, {16'h0000, ch2_latch_word, ch1_counter_word});
    check_val({ch1_preset_word, ch2_preset_word}, {2{32'hdead_beef}});
    check_val({ch1_process_control_byte, ch2_process_control_byte}, 16'h8002);
    check_val({ch1_register_comm_enable, ch2_register_comm_enable, ch1_regcomm_req}, 10'h000);
    check_val(image_bytes, 4'h8);
    $display("compact test done");
    write_size(1'b0);
    i_dcpim_coupler_model.set_mode(1'b1);
    load(8'hb2);
    i_dcpim_coupler_model.send({32'h5555_6666, 8'h00, 32'h1234_5678, 8'h02});
    settle();
    check_val(in_image, {ch2_counter_word, ch2_status_byte, ch1_latch_word, ch1_status_byte});
    check_val({ch1_preset_word, ch2_preset_word}, {32'h1234_5678, 32'h5555_6666});
    check_val(image_bytes, 4'ha);
    i_dcpim_coupler_model.send({32'h5555_6666, 8'h00, 32'h1234_5678,
      i_dcpim_coupler_model.rc_byte(1'b1, 1'b1, 6'h2a)});
    settle();
    check_val({ch1_register_comm_enable, ch1_regcomm_req}, 9'h1ea);
    check_val({in_image[47:40], in_image[7:0]}, {ch2_status_byte, ch1_regcomm_status_byte});
    $display("complete test done");
    write_size(1'b1);
    load(8'hc3);
    i_dcpim_coupler_model.send({32'h0bad_f00d, 8'h85, 8'hff, 8'h00, 8'hff, 8'h82, 8'h00});
    settle();
    check_val(in_image, {ch2_counter_word, ch2_regcomm_status_byte, ch1_latch_word, ch1_regcomm_status_byte});
    check_val({ch1_register_comm_enable, ch2_register_comm_enable, ch2_regcomm_req}, 10'h185);
    check_val({ch1_process_control_byte, ch2_process_control_byte}, 16'h8200);
    check_val({ch1_preset_word, ch2_preset_word, image_bytes}, {{2{32'h0bad_f00d}}, 4'ha});
    // hold the image long enough for the mixed-layout checker windows to complete
    settle();
    $display("mixed test done");
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    check_val({image_size_select_bit, image_bytes, ch1_register_comm_enable, ch2_register_comm_enable}, 7'h60);
    settle();
    check_val({image_bytes, ch2_register_comm_enable}, 5'h15);
    $display("reset again test done");
    tally_and_finish();
  end
endmodule : dcpim_mapper_test
